//--- verilog/sample_fifo_system_control.sv
// register bank and power control for the sample fifo front end
`timescale 1ns/100ps
module sample_fifo_system_control #(
  parameter int FIFO_W = sysctl_pkg::FIFO_WIDTH,
  parameter int FIFO_D = sysctl_pkg::FIFO_DEPTH
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic ext_slow_clock_pin_in,
  input wire logic [3:0] sample_rate_code_in,
  input wire logic sample_valid_in,
  output logic sample_ready_out,
  input wire logic [FIFO_W-1:0] sample_data_in,
  input wire logic conv_busy_in,
  output logic conv_enable_out,
  output logic led_enable_out,
  output logic [3:0] led_item_mask_out,
  output logic osc_enable_out,
  output logic slow_clock_out,
  output logic dyn_powerdown_out,
  output logic power_save_out,
  output logic almost_full_flag_out
);
  import sysctl_pkg::*;

  // ----------------------------------------
  // reset release and forced power-on reset
  // ----------------------------------------
  logic rst_s1_r;
  logic rst_s2_r;
  logic soft_rst_r;
  logic [3:0] por_cnt_r;
  logic rst_n;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;
  logic reset_write;
  assign reset_write = reg_wr_in && (reg_addr_in == ADDR_SYS_CTRL) && reg_wdata_in[BIT_RESET];
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      soft_rst_r <= 1'b0;
      por_cnt_r <= '0;
    end else if (reset_write && !soft_rst_r) begin
      soft_rst_r <= 1'b1;
      por_cnt_r <= POR_CYCLES;
    end else if (soft_rst_r) begin
      por_cnt_r <= por_cnt_r - 4'h1;
      if (por_cnt_r == 4'h1) begin
        soft_rst_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] item_low_r;
  logic [7:0] item_high_r;
  logic [7:0] sys_r;
  logic [3:0] thresh_r;
  logic wr_low;
  logic wr_high;
  logic wr_sys;
  logic wr_cfg;
  assign wr_low = reg_wr_in && !soft_rst_r && (reg_addr_in == ADDR_ITEM_LOW);
  assign wr_high = reg_wr_in && !soft_rst_r && (reg_addr_in == ADDR_ITEM_HIGH);
  assign wr_sys = reg_wr_in && !soft_rst_r && (reg_addr_in == ADDR_SYS_CTRL);
  assign wr_cfg = reg_wr_in && !soft_rst_r && (reg_addr_in == ADDR_FIFO_CFG);
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      item_low_r <= ITEM_RESET;
      item_high_r <= ITEM_RESET;
      thresh_r <= THRESH_RESET;
    end else if (soft_rst_r) begin
      item_low_r <= ITEM_RESET;
      item_high_r <= ITEM_RESET;
      thresh_r <= THRESH_RESET;
    end else begin
      if (wr_low) begin
        item_low_r <= reg_wdata_in;
      end
      if (wr_high) begin
        item_high_r <= reg_wdata_in;
      end
      if (wr_cfg) begin
        thresh_r <= reg_wdata_in[3:0];
      end
    end
  end
  // reset bit never stored; it reads back as one only while the sequence runs
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sys_r <= SYS_RESET;
    end else if (soft_rst_r) begin
      sys_r <= SYS_RESET;
    end else if (wr_sys) begin
      sys_r <= reg_wdata_in & SYS_WMASK;
    end
  end

  // ----------------------------------------
  // fifo enable, flush and conversion control
  // ----------------------------------------
  logic fifo_en;
  logic fifo_en_d_r;
  logic flush;
  logic [3:0] item1_type_select;
  logic [3:0] item2_type_select;
  logic [3:0] item3_type_select;
  logic [3:0] item4_type_select;
  assign item1_type_select = item_low_r[3:0];
  assign item2_type_select = item_low_r[7:4];
  assign item3_type_select = item_high_r[3:0];
  assign item4_type_select = item_high_r[7:4];
  assign fifo_en = sys_r[BIT_FIFO_EN];
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      fifo_en_d_r <= 1'b0;
    end else begin
      fifo_en_d_r <= fifo_en;
    end
  end
  assign flush = (fifo_en && !fifo_en_d_r) || soft_rst_r;

  // ----------------------------------------
  // power save sequencing
  // ----------------------------------------
  typedef enum logic [1:0] {PWR_RUN, PWR_DRAIN, PWR_SAVE} pwr_state_e;
  pwr_state_e pwr_r;
  logic power_save_request;
  assign power_save_request = sys_r[BIT_POWER_SAVE_REQUEST];
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pwr_r <= PWR_RUN;
    end else begin
      unique case (pwr_r)
        PWR_RUN: begin
          if (power_save_request) begin
            pwr_r <= conv_busy_in ? PWR_DRAIN : PWR_SAVE;
          end
        end
        PWR_DRAIN: begin
          if (!power_save_request) begin
            pwr_r <= PWR_RUN;
          end else if (!conv_busy_in) begin
            pwr_r <= PWR_SAVE;
          end
        end
        PWR_SAVE: begin
          if (!power_save_request) begin
            pwr_r <= PWR_RUN;
          end
        end
      endcase
    end
  end
  logic in_save;
  assign in_save = (pwr_r == PWR_SAVE);

  // ----------------------------------------
  // sample path
  // ----------------------------------------
  logic conv_active;
  logic fifo_wr_ready;
  logic [$clog2(FIFO_D):0] fifo_count;
  logic [7:0] fifo_rdata;
  logic fifo_rd_valid;
  logic fifo_pop;
  // conversions run while enabled, or after disable until item1 is none
  // enable stays up while draining so a running conversion can finish
  assign conv_active = (fifo_en || (item1_type_select != TYPE_NONE)) && (pwr_r != PWR_SAVE)
                     && !soft_rst_r;
  assign fifo_pop = reg_rd_in && (reg_addr_in == ADDR_FIFO_DATA);
  sample_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .flush_in(flush),
    .wr_valid_in(sample_valid_in && fifo_en && !in_save),
    .wr_ready_out(fifo_wr_ready),
    .wr_data_in(sample_data_in),
    .rd_valid_out(fifo_rd_valid),
    .rd_ready_in(fifo_pop),
    .rd_data_out(fifo_rdata),
    .count_out(fifo_count)
  );
  // when disabled, samples are accepted and dropped so conversions never stall
  assign sample_ready_out = fifo_en ? fifo_wr_ready : conv_active;

  // ----------------------------------------
  // almost-full flag
  // ----------------------------------------
  logic af_r;
  logic af_hit;
  logic [5:0] af_level;
  assign af_level = FIFO_SLOTS - {2'b00, thresh_r};
  assign af_hit = ({{(5 - $clog2(FIFO_D)){1'b0}}, fifo_count} >= af_level) && fifo_en;
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      af_r <= 1'b0;
    end else if (in_save || soft_rst_r) begin
      af_r <= 1'b0;
    end else if (af_hit) begin
      af_r <= 1'b1;
    end else if (reg_rd_in && reg_addr_in == ADDR_FIFO_COUNT) begin
      af_r <= 1'b0;
    end
  end
  assign almost_full_flag_out = af_r;

  // ----------------------------------------
  // outputs to analogue and clocking
  // ----------------------------------------
  logic slow_rate;
  logic [3:0] led_mask;
  assign slow_rate = (sample_rate_code_in <= SLOW_RATE_MAX) || sample_rate_code_in[3]
                     && (sample_rate_code_in > 4'hA);
  assign led_mask = {item4_type_select != TYPE_NONE, item3_type_select != TYPE_NONE,
                     item2_type_select != TYPE_NONE, item1_type_select != TYPE_NONE};
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      conv_enable_out <= 1'b0;
      led_enable_out <= 1'b0;
      led_item_mask_out <= 4'h0;
      osc_enable_out <= 1'b0;
      slow_clock_out <= 1'b0;
      dyn_powerdown_out <= 1'b0;
      power_save_out <= 1'b0;
    end else begin
      conv_enable_out <= conv_active;
      led_enable_out <= conv_active;
      led_item_mask_out <= conv_active ? led_mask : 4'h0;
      osc_enable_out <= !in_save;
      // external clock only for slow rates; otherwise internal oscillator
      slow_clock_out <= (sys_r[BIT_CLK] && slow_rate) ? ext_slow_clock_pin_in
                        : !in_save;
      dyn_powerdown_out <= sys_r[BIT_LP] && slow_rate && conv_active;
      power_save_out <= in_save;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    reg_rdata_out = 8'h00;
    unique case (reg_addr_in)
      ADDR_ITEM_LOW: reg_rdata_out = item_low_r;
      ADDR_ITEM_HIGH: reg_rdata_out = item_high_r;
      ADDR_FIFO_CFG: reg_rdata_out = {4'h0, thresh_r};
      ADDR_SYS_CTRL: reg_rdata_out = sys_r | {7'h00, soft_rst_r};
      ADDR_FIFO_DATA: reg_rdata_out = fifo_rd_valid ? fifo_rdata : 8'h00;
      ADDR_FIFO_COUNT: reg_rdata_out = {af_r, 1'b0, 6'(fifo_count)};
      default: reg_rdata_out = 8'h00;
    endcase
  end
endmodule // sample_fifo_system_control

//--- verilog/sysctl_pkg.sv
// constants for the sample fifo system control block
// Summary of operation
// - almost-full at 32 minus threshold samples
// - item select low: item1 low, item2 high
// - item select high: item3 low, item4 high
// - clock select: internal or external slow clock
// - dynamic powerdown between samples, slow rates only
// - fifo disable stops pushes, holds pointers, data
// - disabled fifo keeps converting until item1 none
// - fifo enable flushes, restarts from pointer zero
// - fifo enable starts conversions and led drivers
// - shutdown keeps registers, access stays normal
// - entering power-save clears all interrupt flags
// - power-save stops oscillator, results are kept
// - shutdown waits for running conversion to finish
// - only writing one enters power-save
// - reset bit forces power-on reset, self-clears
package sysctl_pkg;
  localparam logic [7:0] ADDR_ITEM_LOW = 8'h09;
  localparam logic [7:0] ADDR_ITEM_HIGH = 8'h0A;
  localparam logic [7:0] ADDR_FIFO_CFG = 8'h08;
  localparam logic [7:0] ADDR_SYS_CTRL = 8'h0D;
  localparam logic [7:0] ADDR_FIFO_DATA = 8'h07;
  localparam logic [7:0] ADDR_FIFO_COUNT = 8'h10;
  localparam logic [7:0] ITEM_RESET = 8'h00;
  localparam logic [7:0] SYS_RESET = 8'h00;
  localparam logic [3:0] THRESH_RESET = 4'hF;
  localparam logic [3:0] TYPE_NONE = 4'h0;
  localparam int BIT_RESET = 0;
  localparam int BIT_POWER_SAVE_REQUEST = 1;
  localparam int BIT_FIFO_EN = 2;
  localparam int BIT_LP = 3;
  localparam int BIT_CLK = 4;
  localparam logic [7:0] SYS_WMASK = 8'h1E;
  localparam logic [5:0] FIFO_SLOTS = 6'h20;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 8;
  localparam logic [3:0] POR_CYCLES = 4'h8;
  localparam logic [3:0] SLOW_RATE_MAX = 4'h4;
endpackage

//--- verilog/sample_fifo.sv
// sample fifo with valid and ready on both sides
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic flush_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out,
  output logic [$clog2(DEPTH):0] count_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [WIDTH-1:0] out_r;
  logic out_valid_r;
  logic push;
  logic pop;
  logic load;
  assign wr_ready_out = (count_r != AW'(0) + (AW+1)'(DEPTH)) && !flush_in;
  assign push = wr_valid_in && wr_ready_out;
  assign load = (count_r != '0) && (!out_valid_r || rd_ready_in) && !flush_in;
  assign pop = load;
  assign rd_valid_out = out_valid_r;
  assign rd_data_out = out_r;
  assign count_out = count_r + (AW+1)'(out_valid_r);
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_r] <= wr_data_in;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (flush_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_r <= '0;
      out_valid_r <= 1'b0;
    end else if (flush_in) begin
      out_valid_r <= 1'b0;
    end else if (load) begin
      out_r <= mem[rd_ptr_r];
      out_valid_r <= 1'b1;
    end else if (rd_ready_in) begin
      out_valid_r <= 1'b0;
    end
  end
endmodule // sample_fifo

//--- bench/sysctl_assertions.sv
// port checker for the sample fifo system control block
`timescale 1ns/100ps
module sysctl_checker
  import sysctl_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [3:0] sample_rate_code_in,
  input wire logic conv_busy_in,
  input wire logic conv_enable_out,
  input wire logic osc_enable_out,
  input wire logic dyn_powerdown_out,
  input wire logic power_save_out,
  input wire logic almost_full_flag_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // accepted control write, soft reset not running
  sequence sys_wr_s;
    reg_wr_in && reg_addr_in == ADDR_SYS_CTRL && !reg_rdata_out[BIT_RESET];
  endsequence
  sequence run_wr_s;
    sys_wr_s ##0 (!reg_wdata_in[BIT_RESET] && !reg_wdata_in[BIT_POWER_SAVE_REQUEST]);
  endsequence
  fifo_start_a: assert property (
    run_wr_s ##0 (reg_wdata_in[BIT_FIFO_EN] && !power_save_out) |-> ##2 conv_enable_out)
    else $error("conversions did not start");
  upper_zero_a: assert property (
    reg_addr_in == ADDR_SYS_CTRL |-> reg_rdata_out[7:5] == 3'h0)
    else $error("unused control bits read back");
  power_save_request_wait_a: assert property (
    $rose(power_save_out) |-> !$past(conv_busy_in))
    else $error("power save entered during a conversion");
  osc_stop_a: assert property (
    power_save_out && $past(power_save_out) |-> !osc_enable_out)
    else $error("oscillator running in power save");
  flag_clear_a: assert property (
    power_save_out && $past(power_save_out) |-> !almost_full_flag_out)
    else $error("flag set in power save");
  power_save_request_exit_a: assert property (
    run_wr_s |-> ##[1:3] !power_save_out)
    else $error("power save kept after clear");
  soft_reset_a: assert property (
    sys_wr_s ##0 reg_wdata_in[BIT_RESET] |-> ##[1:12] (!conv_enable_out && !power_save_out))
    else $error("soft reset left state");
  lp_rate_a: assert property (
    dyn_powerdown_out |->
      ($past(sample_rate_code_in) <= SLOW_RATE_MAX || $past(sample_rate_code_in) >= 4'hB))
    else $error("powerdown at fast rate");
endmodule // sysctl_checker
bind sample_fifo_system_control sysctl_checker u_checker (.core_clk_in, .rst_n_in, .reg_wr_in,
  .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .sample_rate_code_in, .conv_busy_in,
  .conv_enable_out, .osc_enable_out, .dyn_powerdown_out, .power_save_out, .almost_full_flag_out);

//--- bench/sample_source.sv
// behavioural conversion engine feeding the sample push port
`timescale 1ns/100ps
module sample_source (
  input wire logic clk_in,
  input wire logic conv_en_in,
  input wire logic slow_in,
  input wire logic ready_in,
  output logic valid_out = 1'b0,
  output logic [7:0] data_out = 8'hA5,
  output logic busy_out = 1'b0,
  output logic ext_clk_out
);
  logic [7:0] next_r = 8'h01;
  logic [5:0] cnt_r = 6'h00;
  logic [3:0] div_r = 4'h0;
  always @(posedge clk_in) div_r <= div_r + 4'h1;
  assign ext_clk_out = div_r[3];
  // convert, then hold the sample until taken; data line churns when idle
  always @(posedge clk_in) begin
    if (valid_out && ready_in) begin
      valid_out <= 1'b0;
      next_r <= next_r + 8'h01;
      data_out <= ~next_r;
    end else if (!conv_en_in) begin
      valid_out <= 1'b0;
      busy_out <= 1'b0;
      data_out <= ~data_out;
    end else if (busy_out && cnt_r == 6'h00) begin
      busy_out <= 1'b0;
      valid_out <= 1'b1;
      data_out <= next_r;
    end else if (busy_out) begin
      cnt_r <= cnt_r - 6'h01;
      data_out <= ~data_out;
    end else if (!valid_out) begin
      busy_out <= 1'b1;
      cnt_r <= slow_in ? 6'h14 : 6'h02;
    end
  end
endmodule // sample_source

//--- bench/sample_fifo_system_control_tb_top.sv
// self-checking bench for the sample fifo system control block
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module sample_fifo_system_control_tb_top;
  import sysctl_pkg::*;
  logic core_clk_in = 0, rst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0, slow = 0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, sample_data_in;
  logic [7:0] rnd = 8'h12, e, base;
  logic [3:0] sample_rate_code_in = 4'h2;
  logic sample_valid_in, sample_ready_out, conv_busy_in, conv_enable_out, osc_enable_out;
  logic dyn_powerdown_out, power_save_out, almost_full_flag_out, ext_slow_clock_pin_in;
  logic [7:0] exp_q[$];
  int err_count = 0, compares = 0, n;
  always #2 core_clk_in = ~core_clk_in;
  sample_fifo_system_control dut (.core_clk_in, .rst_n_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
    .reg_wdata_in, .reg_rdata_out, .ext_slow_clock_pin_in, .sample_rate_code_in,
    .sample_valid_in, .sample_ready_out, .sample_data_in, .conv_busy_in, .conv_enable_out,
    .led_enable_out(), .led_item_mask_out(), .osc_enable_out, .slow_clock_out(),
    .dyn_powerdown_out, .power_save_out, .almost_full_flag_out);
  sample_source src (.clk_in(core_clk_in), .conv_en_in(conv_enable_out), .slow_in(slow),
    .ready_in(sample_ready_out), .valid_out(sample_valid_in), .data_out(sample_data_in),
    .busy_out(conv_busy_in), .ext_clk_out(ext_slow_clock_pin_in));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    reg_wr_in = 1;
    reg_addr_in = a;
    reg_wdata_in = d;
    cyc(1);
    reg_wr_in = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    cyc(1);
    exp_q.push_back(x);
    reg_rd_in = 1;
    reg_addr_in = a;
    cyc(1);
    reg_rd_in = 0;
  endtask
  task automatic end_sim();
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // read data is compared against the oldest queued note
  always @(posedge core_clk_in) begin
    if (reg_rd_in) begin
      e = exp_q.pop_front();
      `CHK("reg_rdata_out", e, reg_rdata_out)
    end
  end
  initial begin
    #80000;
    err_count++;
    end_sim();
  end
  initial begin
    cyc(2);
    rst_n_in = 1;
    cyc(3);
    rd(ADDR_ITEM_LOW, ITEM_RESET);
    rd(ADDR_ITEM_HIGH, ITEM_RESET);
    rd(ADDR_SYS_CTRL, SYS_RESET);
    rd(ADDR_FIFO_CFG, {4'h0, THRESH_RESET});
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      wr(ADDR_ITEM_LOW, rnd | 8'h01);
      rd(ADDR_ITEM_LOW, rnd | 8'h01);
      rnd = lfsr(rnd);
      wr(ADDR_ITEM_HIGH, rnd);
      rd(ADDR_ITEM_HIGH, rnd);
    end
    wr(ADDR_SYS_CTRL, 8'hF8);
    rd(ADDR_SYS_CTRL, 8'h18);
    wr(ADDR_SYS_CTRL, 8'h1C);
    base = src.next_r;
    cyc(2);
    `CHK("conv_enable_out", 1'b1, conv_enable_out)
    for (n = 0; n < 2000 && sample_ready_out; n++) @(posedge core_clk_in);
    cyc(1);
    rd(ADDR_FIFO_COUNT, 8'h91);
    wr(ADDR_SYS_CTRL, 8'h18);
    cyc(4);
    `CHK("conv_enable_out", 1'b1, conv_enable_out)
    for (int i = 1; i <= 12; i++) rd(ADDR_FIFO_DATA, base + 8'(i - 1));
    rd(ADDR_FIFO_COUNT, 8'h85);
    `CHK("sample_ready_out", 1'b1, sample_ready_out)
    wr(ADDR_ITEM_LOW, 8'h20);
    cyc(4);
    `CHK("conv_enable_out", 1'b0, conv_enable_out)
    slow = 1;
    wr(ADDR_ITEM_LOW, 8'h21);
    wr(ADDR_SYS_CTRL, 8'h1C);
    base = src.next_r;
    rd(ADDR_FIFO_COUNT, 8'h00);
    for (n = 0; n < 200 && !(sample_valid_in && sample_ready_out); n++) @(posedge core_clk_in);
    cyc(1);
    rd(ADDR_FIFO_DATA, base);
    for (n = 0; n < 200 && !conv_busy_in; n++) @(posedge core_clk_in);
    wr(ADDR_SYS_CTRL, 8'h1E);
    cyc(3);
    `CHK("power_save_out", 1'b0, power_save_out)
    for (n = 0; n < 200 && !power_save_out; n++) @(posedge core_clk_in);
    cyc(2);
    `CHK("osc_enable_out", 1'b0, osc_enable_out)
    `CHK("almost_full_flag_out", 1'b0, almost_full_flag_out)
    rd(ADDR_ITEM_LOW, 8'h21);
    wr(ADDR_ITEM_HIGH, 8'h5A);
    rd(ADDR_ITEM_HIGH, 8'h5A);
    rd(ADDR_SYS_CTRL, 8'h1E);
    wr(ADDR_SYS_CTRL, 8'h1C);
    cyc(3);
    `CHK("power_save_out", 1'b0, power_save_out)
    `CHK("dyn_powerdown_out", 1'b1, dyn_powerdown_out)
    sample_rate_code_in = 4'h7;
    cyc(4);
    `CHK("dyn_powerdown_out", 1'b0, dyn_powerdown_out)
    wr(ADDR_SYS_CTRL, 8'h01);
    cyc(12);
    rd(ADDR_SYS_CTRL, SYS_RESET);
    rd(ADDR_ITEM_HIGH, ITEM_RESET);
    rd(ADDR_FIFO_CFG, {4'h0, THRESH_RESET});
    end_sim();
  end
endmodule // sample_fifo_system_control_tb_top
